// ### core/evq_map.svh
// Purpose: Field positions and event encodings for the event qualifier.
// Assumes: Event-select register layout with event code in 7:0 and unit mask in 15:8.
// Notes:   Definitions only.
`ifndef EVQ_MAP_SVH
`define EVQ_MAP_SVH
`define EVQ_CODE_LO      0
`define EVQ_CODE_HI      7
`define EVQ_UMASK_LO     8
`define EVQ_UMASK_HI     15
`define EVQ_CORE_HI      15
`define EVQ_CORE_LO      14
`define EVQ_AGENT_BIT    13
`define EVQ_PF_HI        13
`define EVQ_PF_LO        12
`define EVQ_MESI_HI      11
`define EVQ_MESI_LO      8
`define EVQ_CORE_ALL     2'h3
`define EVQ_CORE_THIS    2'h1
`define EVQ_PF_ALL       2'h3
`define EVQ_PF_ONLY      2'h1
`define EVQ_PF_NONE      2'h0
`define EVQ_EV_REFCYC    8'h3C
`define EVQ_EV_CACHE     8'h2E
`define EVQ_EV_BR        8'hC4
`define EVQ_EV_BRMISS    8'hC5
`define EVQ_UM_REFCYC    8'h01
`define EVQ_UM_CREF      8'h4F
`define EVQ_UM_CMISS     8'h41
`define EVQ_UM_ZERO      8'h00
`endif

// ### core/evq_pkg.sv
// Purpose: Types shared by the event qualifier.
// Assumes: Nothing.
// Notes:   Qualifier class of a model-specific event, one-hot.
package evq_pkg;
    // How the raw model-specific condition may be qualified.
    typedef enum logic [4:0] {
        QC_PLAIN = 5'h01,
        QC_CORE_ONLY = 5'h02,
        QC_AGENT = 5'h04,
        QC_PREFETCH = 5'h08,
        QC_MESI = 5'h10
    } qual_class_t;
endpackage

// ### core/evq_pulse.sv
// Purpose: Registered one-cycle pulse from a qualified level condition.
// Assumes: Condition is sampled every cycle; each cycle is an occurrence.
// Notes:   Keeps the top outputs straight from a flip-flop.
`timescale 1ns/1ns
module evq_pulse (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic cond,
    output logic      pulse_q
);
    // -----------------------------------------------
    // Output register
    // -----------------------------------------------
    // One registered increment per qualified cycle.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pulse_q <= 1'h0;
        end else begin
            pulse_q <= cond;
        end
    end
endmodule

// ### core/perf_event_qualifier.sv
// Purpose: Decode event code and unit mask, drive counter increment request.
// Assumes: Event sources are one-cycle strobes synchronous to ref_clk.
// Notes:   Counter datapath, overflow and global enable live elsewhere.
`timescale 1ns/1ns
`include "evq_map.svh"
module perf_event_qualifier (
    input  wire logic        ref_clk,          // Core clock.
    input  wire logic        sys_rst,          // Async reset, high.
    input  wire logic [15:0] event_select_register, // Event code and unit mask.
    input  wire logic        core_clk_running, // Core not halted.
    input  wire logic        ref_tick,         // Fixed-frequency reference tick.
    input  wire logic        cache_ref,        // Core request to last_level_cache.
    input  wire logic        cache_ref_spec,   // Speculative or L1 prefetch reference.
    input  wire logic        cache_miss,       // Miss on a reference.
    input  wire logic        br_retire,        // Last uop of a branch retired.
    input  wire logic        br_mispred,       // That branch was mispredicted.
    input  wire logic        br_arch_path,     // Branch on architectural path.
    input  wire logic        ms_event_hit,     // Model event code/base mask matched.
    input  wire logic [4:0]  ms_class,         // Qualifier class, evq_pkg::qual_class_t.
    input  wire logic        ms_is_core_spec,  // Event is a core-specific one.
    input  wire logic        ms_this_core,     // Condition from this core.
    input  wire logic        ms_other_core,    // Condition from another core.
    input  wire logic        ms_this_agent,    // Bus condition from this agent.
    input  wire logic        ms_other_agent,   // Bus condition from another agent.
    input  wire logic        ms_prefetch,      // Condition was a hardware prefetch.
    input  wire logic        ms_demand,        // Condition was not a prefetch.
    input  wire logic [3:0]  ms_line_state,    // One-hot M,E,S,I of the line.
    output logic             incr_q,           // One-cycle increment request.
    output logic             arch_hit_q        // Selection matches an architectural event.
);
    // -----------------------------------------------
    // Field extraction
    // -----------------------------------------------
    // unit mask decode
    wire [7:0] code  = event_select_register[`EVQ_CODE_HI:`EVQ_CODE_LO];
    wire [7:0] umask = event_select_register[`EVQ_UMASK_HI:`EVQ_UMASK_LO];
    wire [1:0] core_f  = event_select_register[`EVQ_CORE_HI:`EVQ_CORE_LO];
    wire       agent_f = event_select_register[`EVQ_AGENT_BIT];
    // Bit 13 is shared by the agent and prefetch fields; the class picks the reading.
    wire [1:0] pf_f    = event_select_register[`EVQ_PF_HI:`EVQ_PF_LO];
    wire [3:0] mesi_f  = event_select_register[`EVQ_MESI_HI:`EVQ_MESI_LO];
    evq_pkg::qual_class_t cls;
    assign cls = evq_pkg::qual_class_t'(ms_class);

    // -----------------------------------------------
    // Architectural events
    // -----------------------------------------------
    // reference cycles select
    wire sel_ref   = (code == `EVQ_EV_REFCYC) && (umask == `EVQ_UM_REFCYC);
    wire sel_cref  = (code == `EVQ_EV_CACHE) && (umask == `EVQ_UM_CREF);
    wire sel_cmiss = (code == `EVQ_EV_CACHE) && (umask == `EVQ_UM_CMISS);
    wire sel_br    = (code == `EVQ_EV_BR) && (umask == `EVQ_UM_ZERO);
    wire sel_brm   = (code == `EVQ_EV_BRMISS) && (umask == `EVQ_UM_ZERO);
    // The five selections are disjoint, so at most one term below is live.
    wire arch_sel  = sel_ref | sel_cref | sel_cmiss | sel_br | sel_brm;
    // Reference ticks only count while the core clock runs, frequency-blind.
    // Speculative and first-level prefetch references count with demand ones.
    wire arch_cond = (sel_ref  & ref_tick & core_clk_running)
                   | (sel_cref & (cache_ref | cache_ref_spec))
                   | (sel_cmiss & cache_miss)
                   | (sel_br   & br_retire)
                   | (sel_brm  & br_retire & br_mispred & br_arch_path);

    // -----------------------------------------------
    // Model-specific qualifiers
    // -----------------------------------------------
    // core specificity; reserved codes match nothing
    wire core_ok_raw = (core_f == `EVQ_CORE_ALL)  ? (ms_this_core | ms_other_core) :
                       (core_f == `EVQ_CORE_THIS) ? ms_this_core : 1'h0;
    // core bits only for core-specific events
    wire core_ok = (ms_is_core_spec && cls != evq_pkg::QC_CORE_ONLY) ? core_ok_raw : 1'h1;
    wire agent_ok = agent_f ? (ms_this_agent | ms_other_agent) : ms_this_agent;
    // prefetch qualification; 10B reserved counts nothing
    wire pf_ok = (pf_f == `EVQ_PF_ALL)  ? 1'h1 :
                 (pf_f == `EVQ_PF_ONLY) ? ms_prefetch :
                 (pf_f == `EVQ_PF_NONE) ? ms_demand : 1'h0;
    wire mesi_ok = |(mesi_f & ms_line_state);

    // class is one-hot, so agent and prefetch never both apply
    // A malformed class matches no term below, so it is refused.
    wire class_ok = (cls == evq_pkg::QC_PLAIN)
                  | (cls == evq_pkg::QC_CORE_ONLY)
                  | ((cls == evq_pkg::QC_AGENT)    & agent_ok)
                  | ((cls == evq_pkg::QC_PREFETCH) & pf_ok)
                  | ((cls == evq_pkg::QC_MESI)     & mesi_ok);

    // model events use the same select register
    wire ms_cond = ~arch_sel & ms_event_hit & core_ok & class_ok;

    // -----------------------------------------------
    // Increment output
    // -----------------------------------------------
    // OR of architectural and qualified model conditions, registered pulse
    evq_pulse u_pulse (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .cond    (arch_cond | ms_cond),
        .pulse_q (incr_q)
    );

    // Status flop showing the decoded selection.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            arch_hit_q <= 1'h0;
        end else begin
            arch_hit_q <= arch_sel;
        end
    end

    // -----------------------------------------------
    // Checks
    // -----------------------------------------------
    // Positive checks carry the sampled reset in their antecedent: on the edge that
    // releases reset the flop still saw reset, so no increment can follow that edge.
    // A running core counts every reference tick.
    a_ref_count: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!sys_rst && sel_ref && ref_tick && core_clk_running) |=> incr_q)
        else $error("reference tick not counted");
    // A halted core never counts reference ticks.
    a_ref_halt: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (sel_ref && !core_clk_running) |=> !incr_q)
        else $error("counted while halted");
    // The reference-cycle selection shuts the model path out.
    a_arch_block: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (sel_ref && !ref_tick && ms_event_hit) |=> !incr_q)
        else $error("model event counted under architectural select");
    // Speculative references count as well as demand ones.
    a_cache_ref: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!sys_rst && sel_cref && cache_ref_spec) |=> incr_q)
        else $error("speculative reference missed");
    // A demand reference alone is counted.
    a_ref_demand: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!sys_rst && sel_cref && cache_ref) |=> incr_q)
        else $error("demand reference missed");
    // With no reference at all the request stays low.
    a_ref_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (sel_cref && !cache_ref && !cache_ref_spec) |=> !incr_q)
        else $error("reference counted without a reference");
    // The miss selection counts only real misses.
    a_cache_miss: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (sel_cmiss && !cache_miss) |=> !incr_q)
        else $error("miss counted without miss");
    // Every selected miss is counted.
    a_miss_count: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!sys_rst && sel_cmiss && cache_miss) |=> incr_q)
        else $error("cache miss not counted");
    // One count per retiring branch.
    a_br_ret: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!sys_rst && sel_br && br_retire) |=> incr_q)
        else $error("branch retire not counted");
    // No retirement, no count.
    a_br_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (sel_br && !br_retire) |=> !incr_q)
        else $error("branch counted without retirement");
    // Branches off the architectural path are never counted as mispredicts.
    a_br_miss: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (sel_brm && !br_arch_path) |=> !incr_q)
        else $error("off-path mispredict counted");
    // A retired, mispredicted, on-path branch is counted.
    a_mispred_count: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!sys_rst && sel_brm && br_retire && br_mispred && br_arch_path) |=> incr_q)
        else $error("mispredicted branch not counted");
    // The status flop follows the decoded selection one cycle later.
    a_arch_status: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!sys_rst && arch_sel) |=> arch_hit_q)
        else $error("architectural selection not shown");

    // -----------------------------------------------
    // Checks: model-specific qualifiers
    // -----------------------------------------------
    // Without a raw hit the model path never counts.
    a_model_hit: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!arch_sel && !ms_event_hit) |=> !incr_q)
        else $error("model event counted without a hit");
    // An empty state mask blocks the count.
    a_mesi_empty: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!arch_sel && cls == evq_pkg::QC_MESI && mesi_f == 4'h0) |=> !incr_q)
        else $error("empty state mask counted");
    // An enabled state that matches the line is counted.
    a_mesi_match: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!sys_rst && !arch_sel && ms_event_hit && !ms_is_core_spec && cls == evq_pkg::QC_MESI
         && (mesi_f & ms_line_state) != 4'h0) |=> incr_q)
        else $error("enabled line state not counted");
    // This-core scope drops conditions from other cores.
    a_core_this: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!arch_sel && ms_is_core_spec && cls == evq_pkg::QC_PLAIN && core_f == `EVQ_CORE_THIS
         && !ms_this_core) |=> !incr_q)
        else $error("other core counted");
    // Reserved core codes count nothing.
    a_core_rsvd: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!arch_sel && ms_is_core_spec && cls != evq_pkg::QC_CORE_ONLY && core_f != `EVQ_CORE_ALL
         && core_f != `EVQ_CORE_THIS) |=> !incr_q)
        else $error("reserved core code counted");
    // Events that are not core-specific ignore the core bits.
    a_core_ignored: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!sys_rst && !arch_sel && ms_event_hit && !ms_is_core_spec && cls == evq_pkg::QC_PLAIN)
         |=> incr_q)
        else $error("core bits applied to a plain event");
    // Core-only conditions ignore both topology qualifiers.
    a_core_only: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!sys_rst && !arch_sel && ms_event_hit && cls == evq_pkg::QC_CORE_ONLY) |=> incr_q)
        else $error("core-only condition not counted");
    // This-agent scope drops conditions from other agents.
    a_agent_this: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!arch_sel && cls == evq_pkg::QC_AGENT && !agent_f && !ms_this_agent) |=> !incr_q)
        else $error("other agent counted");
    // Excluding prefetches drops prefetch conditions.
    a_pf_excl: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!arch_sel && cls == evq_pkg::QC_PREFETCH && pf_f == `EVQ_PF_NONE && !ms_demand) |=> !incr_q)
        else $error("prefetch counted when excluded");
    // Prefetch-only scope drops demand conditions.
    a_pf_only: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!arch_sel && cls == evq_pkg::QC_PREFETCH && pf_f == `EVQ_PF_ONLY && !ms_prefetch) |=> !incr_q)
        else $error("demand counted when prefetch only");
    // The reserved prefetch code counts nothing.
    a_pf_reserved: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!arch_sel && cls == evq_pkg::QC_PREFETCH && pf_f != `EVQ_PF_ALL && pf_f != `EVQ_PF_ONLY
         && pf_f != `EVQ_PF_NONE) |=> !incr_q)
        else $error("reserved prefetch code counted");
    // A class that is not one-hot could mix agent and prefetch readings, so it never counts.
    a_bad_class: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!arch_sel && !$onehot(ms_class)) |=> !incr_q)
        else $error("malformed class counted");
endmodule

// ### tb/test_perf_event_qualifier.sv
// Purpose: Self-checking bench for the event qualifier, against a reference model built from the rules.
// Assumes: Outputs answer just after the edge that samples the inputs; reset forces them low.
// Notes:   Random selections from an LFSR seeded at 8; a second reset is applied in mid-run.
`timescale 1ns/1ns
// Compares one design value with its model value, four-state exact.
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module test_perf_event_qualifier;
    // ----------------------------------------------------------------
    // Stimulus and observation signals
    // ----------------------------------------------------------------
    logic        ref_clk, sys_rst;                    // Clock and async reset.
    logic [15:0] event_select_register;               // Code in 7:0, unit mask in 15:8.
    logic        core_clk_running, ref_tick;          // Reference cycle sources.
    logic        cache_ref, cache_ref_spec, cache_miss; // Cache sources.
    logic        br_retire, br_mispred, br_arch_path; // Branch sources.
    logic        ms_event_hit, ms_is_core_spec;       // Model event raw hit and kind.
    logic [4:0]  ms_class;                            // Qualifier class, one-hot or arbitrary.
    logic        ms_this_core, ms_other_core;         // Core origin.
    logic        ms_this_agent, ms_other_agent;       // Bus agent origin.
    logic        ms_prefetch, ms_demand;              // Prefetch or demand origin.
    logic [3:0]  ms_line_state;                       // One-hot line state.
    logic        incr_q, arch_hit_q;                  // Design outputs.
    logic [31:0] r1, r2;                              // Random words.
    logic [1:0]  exp_v;                               // Model result: arch hit, increment.
    int          n_errors, tests_run;                 // Report counters.

    perf_event_qualifier dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .event_select_register(event_select_register),
        .core_clk_running(core_clk_running), .ref_tick(ref_tick), .cache_ref(cache_ref),
        .cache_ref_spec(cache_ref_spec), .cache_miss(cache_miss), .br_retire(br_retire),
        .br_mispred(br_mispred), .br_arch_path(br_arch_path), .ms_event_hit(ms_event_hit),
        .ms_class(ms_class), .ms_is_core_spec(ms_is_core_spec), .ms_this_core(ms_this_core),
        .ms_other_core(ms_other_core), .ms_this_agent(ms_this_agent), .ms_other_agent(ms_other_agent),
        .ms_prefetch(ms_prefetch), .ms_demand(ms_demand), .ms_line_state(ms_line_state),
        .incr_q(incr_q), .arch_hit_q(arch_hit_q)
    );

    // Free-running 100 MHz clock.
    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Galois-free 32-bit LFSR step; called many times per cycle to decorrelate fields.
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // ----------------------------------------------------------------
    // Reference model: returns {architectural hit, increment condition}
    // ----------------------------------------------------------------
    function automatic logic [1:0] ref_model();
        logic [7:0] c;
        logic [7:0] u;
        logic       a;
        logic       q;
        logic       core_ok;
        c = event_select_register[7:0];
        u = event_select_register[15:8];
        a = (c == 8'h3C && u == 8'h01) || (c == 8'h2E && (u == 8'h4F || u == 8'h41)) ||
            ((c == 8'hC4 || c == 8'hC5) && u == 8'h00);
        core_ok = !ms_is_core_spec || ms_class == evq_pkg::QC_CORE_ONLY ||
                  (u[7:6] == 2'h3 && (ms_this_core || ms_other_core)) || (u[7:6] == 2'h1 && ms_this_core);
        case (ms_class)
            evq_pkg::QC_PLAIN, evq_pkg::QC_CORE_ONLY: q = 1'h1;
            evq_pkg::QC_AGENT: q = u[5] ? (ms_this_agent || ms_other_agent) : ms_this_agent;
            evq_pkg::QC_PREFETCH: q = (u[5:4] == 2'h3) || (u[5:4] == 2'h1 && ms_prefetch) ||
                                      (u[5:4] == 2'h0 && ms_demand);
            evq_pkg::QC_MESI: q = |(u[3:0] & ms_line_state);
            default: q = 1'h0;
        endcase
        if (c == 8'h3C && u == 8'h01) q = core_clk_running && ref_tick;
        else if (c == 8'h2E && u == 8'h4F) q = cache_ref || cache_ref_spec;
        else if (c == 8'h2E && u == 8'h41) q = cache_miss;
        else if (c == 8'hC4 && u == 8'h00) q = br_retire;
        else if (c == 8'hC5 && u == 8'h00) q = br_retire && br_mispred && br_arch_path;
        else q = ms_event_hit && core_ok && q;
        return {a, q};
    endfunction

    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence: random selections every cycle, reset again at 2000
    // ----------------------------------------------------------------
    initial begin
        n_errors = 0;
        tests_run = 0;
        r1 = 32'h0000_0008;
        r2 = 32'h0000_0000;
        sys_rst = 1'h1;
        {event_select_register, core_clk_running, ref_tick, cache_ref, cache_ref_spec, cache_miss} = '0;
        {br_retire, br_mispred, br_arch_path, ms_event_hit, ms_class, ms_is_core_spec} = '0;
        {ms_this_core, ms_other_core, ms_this_agent, ms_other_agent, ms_prefetch, ms_demand} = '0;
        ms_line_state = 4'h0;
        for (int i = 0; i < 4000; i++) begin
            @(posedge ref_clk);
            // The design samples the values standing now; its answer shows after this edge.
            // Reset raised at iteration 2000 clears the outputs within the same time step.
            exp_v = (sys_rst || i == 2000) ? 2'h0 : ref_model();
            for (int k = 0; k < 64; k++) begin
                r2 = {r2[30:0], r1[31]};
                r1 = lfsr_next(r1);
            end
            // Bias toward the five architectural selections; the rest are arbitrary codes and masks.
            case (r1[2:0])
                3'h0: event_select_register <= 16'h013C;
                3'h1: event_select_register <= 16'h4F2E;
                3'h2: event_select_register <= 16'h412E;
                3'h3: event_select_register <= 16'h00C4;
                3'h4: event_select_register <= 16'h00C5;
                default: event_select_register <= r2[15:0];
            endcase
            // Mostly legal one-hot classes, sometimes an arbitrary value that counts only if it happens to be one-hot.
            ms_class <= (r2[18:16] < 3'h5) ? (5'h01 << r2[18:16]) : r2[23:19];
            {core_clk_running, ref_tick, cache_ref, cache_ref_spec, cache_miss} <= r1[7:3];
            {br_retire, br_mispred, br_arch_path, ms_event_hit, ms_is_core_spec} <= r1[12:8];
            // Origins are kept consistent: a condition comes from at least one place.
            ms_this_core <= r1[13];
            ms_other_core <= ~r1[13] | r1[14];
            ms_this_agent <= r1[15];
            ms_other_agent <= ~r1[15] | r1[16];
            ms_prefetch <= r1[17];
            ms_demand <= ~r1[17];
            ms_line_state <= 4'h1 << r1[19:18];
            sys_rst <= (i < 4) || (i >= 2000 && i < 2003);
            #1;
            `CHK("arch_hit_q", exp_v[1], arch_hit_q)
            if (exp_v[1]) `CHK("incr_q arch", exp_v[0], incr_q)
            else `CHK("incr_q model", exp_v[0], incr_q)
        end
        end_sim();
    end
endmodule
